// ===== src/adcsq_consts.svh
// Offsets, field positions, reset values and timing counts of the converter
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH
`define ADCSQ_OFS_CTRL0       4'h0
`define ADCSQ_OFS_CTRL1       4'h1
`define ADCSQ_OFS_CTRL2       4'h2
`define ADCSQ_OFS_RES_HIGH    4'h3
`define ADCSQ_OFS_RES_LOW     4'h4
`define ADCSQ_OFS_STATUS      4'h5
`define ADCSQ_OFS_ANALOG_DATA 4'h6
`define ADCSQ_C0_CALIB        7
`define ADCSQ_C0_GO           1
`define ADCSQ_C0_ON           0
`define ADCSQ_C2_ALIGN        7
`define ADCSQ_RST_CTRL0       8'h00
`define ADCSQ_RST_CTRL1       8'h00
`define ADCSQ_RST_CTRL2       8'h00
`define ADCSQ_CONV_PERIODS    4'hB
`define ADCSQ_WAIT_PERIODS    5'h02
`define ADCSQ_SPEC_TRIG_MODE  4'hB
`define ADCSQ_RC_DIV          8'h40
`define ADCSQ_TCY_CLOCKS      8'h04
`endif

// ===== src/adcsq_pkg.sv
// Types shared by the converter sequencer
package adcsq_pkg;
   typedef enum logic [2:0] {
      ADCSQ_IDLE   = 3'b000,
      ADCSQ_DELAY  = 3'b001,
      ADCSQ_ACQ    = 3'b011,
      ADCSQ_CONV   = 3'b010,
      ADCSQ_WAIT   = 3'b110
   } adcsq_state_t;
   typedef struct packed {
      logic       calib;
      logic [3:0] channel;
      logic       go;
      logic       on;
   } adcsq_ctrl0_t;
   typedef struct packed {
      logic       hold_open;
      logic       calib_cycle;
      logic [3:0] channel;
      logic       neg_ext;
      logic       pos_ext;
   } adcsq_analog_t;
endpackage

// ===== src/adcsq_top.sv
// Sequencer and registers of the 10-bit successive-approximation converter
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adcsq_top #(
   parameter int unsigned NUM_CHANNELS = 15
) (
   input  wire logic                   i_clock,
   input  wire logic                   i_rst_b,
   input  wire logic [3:0]             i_addr,
   input  wire logic [7:0]             i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output logic [7:0]                  o_rdata,
   input  wire logic                   i_rc_clock,
   input  wire logic                   i_cmp_out,
   input  wire logic                   i_spec_trigger,
   input  wire logic [3:0]             i_ccp_mode,
   output adcsq_pkg::adcsq_analog_t    o_analog,
   output logic                        o_ref_neg_ext,
   output logic                        o_ref_pos_ext,
   output logic [NUM_CHANNELS-1:0]     o_pin_analog,
   output logic [9:0]                  o_dac_code,
   output logic                        o_done_flag
);
   adcsq_pkg::adcsq_state_t state_q;
   adcsq_pkg::adcsq_ctrl0_t ctrl0_q;
   logic [5:0]  ctrl1_q;
   logic [7:0]  ctrl2_q;
   logic [7:0]  res_high_q;
   logic [7:0]  res_low_q;
   logic        done_q;
   logic [7:0]  div_q;
   logic [4:0]  tad_cnt_q;
   logic [9:0]  sar_q;
   logic [9:0]  bit_q;
   logic [9:0]  offset_q;
   logic        calib_run_q;
   logic [1:0]  rc_sync_q;
   logic        rc_prev_q;
   logic        cmp_s1_q;
   logic        cmp_s2_q;
   logic [1:0]  trig_sync_q;
   logic        trig_prev_q;
   logic [7:0]  div_lim;
   logic        use_rc;
   logic        tad_tick;
   logic [4:0]  acq_periods;
   logic        go_cmd;
   logic        go_clear;
   logic        trig_pulse;
   logic        conv_end;
   logic [9:0]  result;
   logic [9:0]  trial;
   logic [9:0]  sar_final;

   // Pin inputs pass two flops before use
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rc_sync_q   <= 2'h0;
         rc_prev_q   <= 1'b0;
         cmp_s1_q    <= 1'b0;
         cmp_s2_q    <= 1'b0;
         trig_sync_q <= 2'h0;
         trig_prev_q <= 1'b0;
      end
      else
      begin
         rc_sync_q   <= {rc_sync_q[0], i_rc_clock};
         rc_prev_q   <= rc_sync_q[1];
         cmp_s1_q    <= i_cmp_out;
         cmp_s2_q    <= cmp_s1_q;
         trig_sync_q <= {trig_sync_q[0], i_spec_trigger};
         trig_prev_q <= trig_sync_q[1];
      end
   end

   assign use_rc = (ctrl2_q[1:0] == 2'h3);
   // Divider length in clocks minus one per code
   always_comb
   begin
      unique case (ctrl2_q[2:0])
         3'h0:    div_lim = 8'h01;
         3'h1:    div_lim = 8'h07;
         3'h2:    div_lim = 8'h1F;
         3'h4:    div_lim = 8'h03;
         3'h5:    div_lim = 8'h0F;
         3'h6:    div_lim = 8'h3F;
         default: div_lim = 8'h00;
      endcase
   end
   assign tad_tick = use_rc ? (rc_sync_q[1] & ~rc_prev_q)
                            : (div_q == div_lim);
   always_comb
   begin
      unique case (ctrl2_q[5:3])
         3'h0: acq_periods = 5'd0;
         3'h1: acq_periods = 5'd2;
         3'h2: acq_periods = 5'd4;
         3'h3: acq_periods = 5'd6;
         3'h4: acq_periods = 5'd8;
         3'h5: acq_periods = 5'd12;
         3'h6: acq_periods = 5'd16;
         3'h7: acq_periods = 5'd20;
      endcase
   end

   assign trig_pulse = trig_sync_q[1] & ~trig_prev_q
                     & (i_ccp_mode == `ADCSQ_SPEC_TRIG_MODE);
   assign go_cmd = ctrl0_q.on & (state_q == adcsq_pkg::ADCSQ_IDLE)
                 & (trig_pulse | (i_wr & (i_addr == `ADCSQ_OFS_CTRL0)
                    & i_wdata[`ADCSQ_C0_GO]));
   assign go_clear = i_wr & (i_addr == `ADCSQ_OFS_CTRL0)
                   & ~i_wdata[`ADCSQ_C0_GO];
   assign conv_end = (state_q == adcsq_pkg::ADCSQ_CONV) & tad_tick
                   & ctrl0_q.on & ~go_clear
                   & (tad_cnt_q == `ADCSQ_CONV_PERIODS - 4'h1);

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         div_q <= 8'h00;
      else if (state_q == adcsq_pkg::ADCSQ_IDLE || tad_tick)
         div_q <= 8'h00;
      else
         div_q <= div_q + 8'h01;
   end

   // Sequencer; go stays set through acquisition and conversion
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_q   <= adcsq_pkg::ADCSQ_IDLE;
         tad_cnt_q <= 5'h00;
      end
      else if (!ctrl0_q.on || (go_clear &&
               state_q != adcsq_pkg::ADCSQ_IDLE &&
               state_q != adcsq_pkg::ADCSQ_WAIT))
      begin
         state_q   <= ctrl0_q.on ? adcsq_pkg::ADCSQ_WAIT
                                 : adcsq_pkg::ADCSQ_IDLE;
         tad_cnt_q <= 5'h00;
      end
      else
      begin
         unique case (state_q)
            adcsq_pkg::ADCSQ_IDLE:
               if (go_cmd)
               begin
                  tad_cnt_q <= 5'h00;
                  if (use_rc)
                     state_q <= adcsq_pkg::ADCSQ_DELAY;
                  else if (acq_periods == 5'd0)
                     state_q <= adcsq_pkg::ADCSQ_CONV;
                  else
                     state_q <= adcsq_pkg::ADCSQ_ACQ;
               end
            adcsq_pkg::ADCSQ_DELAY:
               if (tad_cnt_q == 5'(`ADCSQ_TCY_CLOCKS - 8'h01))
               begin
                  tad_cnt_q <= 5'h00;
                  state_q   <= (acq_periods == 5'd0)
                             ? adcsq_pkg::ADCSQ_CONV
                             : adcsq_pkg::ADCSQ_ACQ;
               end
               else
                  tad_cnt_q <= tad_cnt_q + 5'h01;
            adcsq_pkg::ADCSQ_ACQ:
               if (tad_tick)
               begin
                  if (tad_cnt_q == acq_periods - 5'h01)
                  begin
                     tad_cnt_q <= 5'h00;
                     state_q   <= adcsq_pkg::ADCSQ_CONV;
                  end
                  else
                     tad_cnt_q <= tad_cnt_q + 5'h01;
               end
            adcsq_pkg::ADCSQ_CONV:
               if (tad_tick)
               begin
                  tad_cnt_q <= conv_end ? 5'h00 : tad_cnt_q + 5'h01;
                  if (conv_end)
                     state_q <= adcsq_pkg::ADCSQ_WAIT;
               end
            adcsq_pkg::ADCSQ_WAIT:
               if (tad_tick)
               begin
                  if (tad_cnt_q == `ADCSQ_WAIT_PERIODS - 5'h01)
                  begin
                     tad_cnt_q <= 5'h00;
                     state_q   <= adcsq_pkg::ADCSQ_IDLE;
                  end
                  else
                     tad_cnt_q <= tad_cnt_q + 5'h01;
               end
            default:
               state_q <= adcsq_pkg::ADCSQ_IDLE;
         endcase
      end
   end

   // Successive approximation, one bit per period after the first
   assign trial = sar_q | bit_q;
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         sar_q <= 10'h000;
         bit_q <= 10'h200;
      end
      else if (state_q != adcsq_pkg::ADCSQ_CONV)
      begin
         sar_q <= 10'h000;
         bit_q <= 10'h200;
      end
      else if (tad_tick && tad_cnt_q != 5'h00 && bit_q != 10'h000)
      begin
         if (cmp_s2_q)
            sar_q <= trial;
         bit_q <= bit_q >> 1;
      end
   end
   // Any channel code converts; missing inputs give undefined data
   // The last bit is decided on the edge that loads the result
   assign sar_final = cmp_s2_q ? trial : sar_q;
   assign result    = sar_final - offset_q;

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         offset_q    <= 10'h000;
         calib_run_q <= 1'b0;
      end
      else
      begin
         if (go_cmd)
            calib_run_q <= ctrl0_q.calib;
         if (conv_end && calib_run_q)
            offset_q <= sar_final;
      end
   end

   // Result pair has no reset: unknown until written or loaded
   always_ff @(posedge i_clock)
   begin
      if (conv_end && !calib_run_q)
      begin
         if (ctrl2_q[`ADCSQ_C2_ALIGN])
         begin
            res_high_q <= {6'h00, result[9:8]};
            res_low_q  <= result[7:0];
         end
         else
         begin
            res_high_q <= result[9:2];
            res_low_q  <= {result[1:0], 6'h00};
         end
      end
      else if (i_wr && i_addr == `ADCSQ_OFS_RES_HIGH)
         res_high_q <= i_wdata;
      else if (i_wr && i_addr == `ADCSQ_OFS_RES_LOW)
         res_low_q <= i_wdata;
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         ctrl0_q <= adcsq_pkg::adcsq_ctrl0_t'(`ADCSQ_RST_CTRL0 >> 1);
         ctrl1_q <= 6'(`ADCSQ_RST_CTRL1);
         ctrl2_q <= `ADCSQ_RST_CTRL2;
      end
      else
      begin
         if (i_wr && i_addr == `ADCSQ_OFS_CTRL0)
         begin
            ctrl0_q.calib   <= i_wdata[`ADCSQ_C0_CALIB];
            ctrl0_q.channel <= i_wdata[5:2];
            ctrl0_q.on      <= i_wdata[`ADCSQ_C0_ON];
         end
         if (conv_end || !ctrl0_q.on || go_clear)
            ctrl0_q.go <= 1'b0;
         if (go_cmd)
            ctrl0_q.go <= 1'b1;
         if (i_wr && i_addr == `ADCSQ_OFS_CTRL1)
            ctrl1_q <= i_wdata[5:0];
         if (i_wr && i_addr == `ADCSQ_OFS_CTRL2)
            ctrl2_q <= {i_wdata[7], 1'b0, i_wdata[5:0]};
      end
   end

   // Done flag: set wins over a software clear
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         done_q <= 1'b0;
      else if (conv_end)
         done_q <= 1'b1;
      else if (i_wr && i_addr == `ADCSQ_OFS_STATUS && i_wdata[0])
         done_q <= 1'b0;
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_rdata <= 8'h00;
      else if (i_rd)
      begin
         unique case (i_addr)
            `ADCSQ_OFS_CTRL0:      o_rdata <= {ctrl0_q.calib, 1'b0,
                                      ctrl0_q.channel, ctrl0_q.go,
                                      ctrl0_q.on};
            `ADCSQ_OFS_CTRL1:      o_rdata <= {2'h0, ctrl1_q};
            `ADCSQ_OFS_CTRL2:      o_rdata <= ctrl2_q;
            `ADCSQ_OFS_RES_HIGH:   o_rdata <= res_high_q;
            `ADCSQ_OFS_RES_LOW:    o_rdata <= res_low_q;
            `ADCSQ_OFS_STATUS:     o_rdata <= {7'h00, done_q};
            default:               o_rdata <= 8'h00;
         endcase
      end
      else
         o_rdata <= 8'h00;
   end

   // Analog-side outputs, all registered
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_analog      <= '0;
         o_ref_neg_ext <= 1'b0;
         o_ref_pos_ext <= 1'b0;
         o_dac_code    <= 10'h000;
         o_done_flag   <= 1'b0;
      end
      else
      begin
         // Capacitor leaves the pin while converting
         o_analog.hold_open   <= (state_q == adcsq_pkg::ADCSQ_CONV);
         o_analog.calib_cycle <= calib_run_q &
                                 (state_q == adcsq_pkg::ADCSQ_CONV);
         o_analog.channel     <= ctrl0_q.channel;
         o_analog.neg_ext     <= ctrl1_q[5];
         o_analog.pos_ext     <= ctrl1_q[4];
         o_ref_neg_ext        <= ctrl1_q[5];
         o_ref_pos_ext        <= ctrl1_q[4];
         o_dac_code           <= trial;
         o_done_flag          <= done_q;
      end
   end

   // Channel c is analog while code + c < 15; code 0 makes all analog
   // Bit k skips the missing fifth input, so bit 5 is channel 6
   genvar k;
   generate
      for (k = 0; k < NUM_CHANNELS; k++)
      begin : g_pin
         localparam int unsigned CHAN = (k < 5) ? k : k + 1;
         always_ff @(posedge i_clock or negedge i_rst_b)
         begin
            if (!i_rst_b)
               o_pin_analog[k] <= 1'b1;
            else
               o_pin_analog[k] <= (ctrl1_q[3:0] == 4'h0)
                                  || ({1'b0, ctrl1_q[3:0]} + 5'(CHAN)
                                      < 5'd15);
         end
      end
   endgenerate

   chk_conv_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      $rose(state_q == adcsq_pkg::ADCSQ_CONV) |=> o_analog.hold_open)
      else $error("hold not opened at conversion");
   chk_done_go_clr: assert property (@(posedge i_clock)
      disable iff (!i_rst_b) conv_end |=> (!ctrl0_q.go && done_q))
      else $error("done did not clear go or set flag");
   chk_off_no_start: assert property (@(posedge i_clock)
      disable iff (!i_rst_b) !ctrl0_q.on |=> !ctrl0_q.go)
      else $error("go set while off");
   chk_wait_after: assert property (@(posedge i_clock)
      disable iff (!i_rst_b) conv_end |=> state_q == adcsq_pkg::ADCSQ_WAIT)
      else $error("no wait after conversion");
   chk_go_zero_acq: assert property (@(posedge i_clock)
      disable iff (!i_rst_b) (go_cmd && !use_rc && acq_periods == 5'd0)
      |=> state_q == adcsq_pkg::ADCSQ_CONV)
      else $error("zero acquisition did not convert");
   chk_rc_delay: assert property (@(posedge i_clock)
      disable iff (!i_rst_b) (go_cmd && use_rc)
      |=> state_q == adcsq_pkg::ADCSQ_DELAY)
      else $error("rc delay missing");
   chk_go_busy: assert property (@(posedge i_clock)
      disable iff (!i_rst_b) (state_q == adcsq_pkg::ADCSQ_ACQ) |-> ctrl0_q.go)
      else $error("go clear during acquisition");
   chk_abort_hold: assert property (@(posedge i_clock)
      disable iff (!i_rst_b) (go_clear && state_q == adcsq_pkg::ADCSQ_CONV)
      |=> $stable(res_high_q) && state_q == adcsq_pkg::ADCSQ_WAIT)
      else $error("abort changed result");
endmodule

// ===== bench/adcsq_analog_model.sv
// Behavioural analog multiplexer and sample-and-hold feeding the comparator
`timescale 1ns/1ps
module adcsq_analog_model (
   input  wire logic                     i_clock,
   input  wire adcsq_pkg::adcsq_analog_t i_analog,
   input  wire logic [9:0]               i_dac_code,
   output logic                          o_cmp_out
);
   logic [9:0] held_q;
   // Each channel carries a distinct level so a wrong channel shows
   always_ff @(posedge i_clock)
   begin
      if (!i_analog.hold_open)
      begin
         held_q <= {i_analog.channel, 6'h25};
      end
   end
   // Dummy conversion sees no input, only a small built-in offset of 2
   always_comb
   begin
      o_cmp_out = i_analog.calib_cycle ? (10'h002 >= i_dac_code)
                                       : (held_q >= i_dac_code);
   end
endmodule

// ===== bench/adc_sequencer_control_tb.sv
// Self-checking testbench of the converter sequencer
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adc_sequencer_control_tb;
   logic                     i_clock;
   logic                     i_rst_b;
   logic                     i_wr;
   logic                     i_rd;
   logic                     i_rc_clock;
   logic                     i_spec_trigger;
   logic                     cmp_out;
   logic                     o_ref_neg_ext;
   logic                     o_ref_pos_ext;
   logic                     o_done_flag;
   logic [3:0]               i_addr;
   logic [3:0]               i_ccp_mode;
   logic [7:0]               i_wdata;
   logic [7:0]               o_rdata;
   logic [7:0]               rv;
   logic [14:0]              o_pin_analog;
   logic [9:0]               o_dac_code;
   adcsq_pkg::adcsq_analog_t o_analog;
   int                       num_errors;
   int                       cmp_count;
   int                       acq;
   int                       conv;
   int                       div [6] = '{2, 8, 32, 4, 16, 64};

   adcsq_top dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_rc_clock(i_rc_clock), .i_cmp_out(cmp_out),
      .i_spec_trigger(i_spec_trigger), .i_ccp_mode(i_ccp_mode),
      .o_analog(o_analog), .o_ref_neg_ext(o_ref_neg_ext),
      .o_ref_pos_ext(o_ref_pos_ext), .o_pin_analog(o_pin_analog),
      .o_dac_code(o_dac_code), .o_done_flag(o_done_flag));

   adcsq_analog_model partner (.i_clock(i_clock), .i_analog(o_analog),
      .i_dac_code(o_dac_code), .o_cmp_out(cmp_out));

   always #2 i_clock = ~i_clock;
   always #20 i_rc_clock = ~i_rc_clock;

   task check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task results();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask

   task rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   // Count cycles until the hold switch reaches the given state
   task wait_hold(input logic lvl, output int n);
      n = 0;
      while (o_analog.hold_open !== lvl)
      begin
         @(posedge i_clock);
         #1;
         n++;
         if (n > 3000)
         begin
            num_errors++;
            results();
         end
      end
   endtask

   task run_conv(input logic [7:0] c0);
      wr(`ADCSQ_OFS_CTRL0, c0);
      wait_hold(1'b1, acq);
      wait_hold(1'b0, conv);
      repeat (160) @(posedge i_clock);
   endtask

   task test_reset();
      rd(`ADCSQ_OFS_CTRL0, rv);
      check(rv, `ADCSQ_RST_CTRL0);
      rd(`ADCSQ_OFS_CTRL1, rv);
      check(rv, `ADCSQ_RST_CTRL1);
      rd(`ADCSQ_OFS_CTRL2, rv);
      check(rv, `ADCSQ_RST_CTRL2);
      rd(4'hF, rv);
      check(rv, 8'h00);
      check(o_pin_analog, 16'h7FFF);
      $display("test reset done");
   endtask

   task test_pins();
      wr(`ADCSQ_OFS_CTRL1, 8'h3F);
      rd(`ADCSQ_OFS_CTRL1, rv);
      check(rv, 8'h3F);
      check({o_ref_neg_ext, o_ref_pos_ext}, 16'h0003);
      check(o_pin_analog, 16'h0000);
      wr(`ADCSQ_OFS_CTRL1, 8'h25);
      rd(`ADCSQ_OFS_CTRL1, rv);
      check({o_ref_neg_ext, o_ref_pos_ext}, 16'h0002);
      check(o_pin_analog, 16'h01FF);
      wr(`ADCSQ_OFS_CTRL1, 8'h0A);
      rd(`ADCSQ_OFS_CTRL1, rv);
      check(rv, 8'h0A);
      check(o_pin_analog, 16'h001F);
      wr(`ADCSQ_OFS_CTRL1, 8'h00);
      repeat (2) @(posedge i_clock);
      #1;
      check({o_ref_neg_ext, o_ref_pos_ext}, 16'h0000);
      check(o_pin_analog, 16'h7FFF);
      $display("test pins done");
   endtask

   task test_right();
      wr(`ADCSQ_OFS_CTRL2, 8'h86);
      wr(`ADCSQ_OFS_CTRL0, 8'h0D);
      run_conv(8'h0F);
      check(acq <= 8, 1'b1);
      check(conv >= 704 && conv <= 768, 1'b1);
      rd(`ADCSQ_OFS_CTRL0, rv);
      check(rv, 8'h0D);
      rd(`ADCSQ_OFS_STATUS, rv);
      check(rv[0], 1'b1);
      check(o_done_flag, 1'b1);
      rd(`ADCSQ_OFS_RES_HIGH, rv);
      check(rv, 8'h00);
      rd(`ADCSQ_OFS_RES_LOW, rv);
      check(rv, 8'hE5);
      wr(`ADCSQ_OFS_STATUS, 8'h01);
      rd(`ADCSQ_OFS_STATUS, rv);
      check(rv[0], 1'b0);
      $display("test right done");
   endtask

   task test_left();
      wr(`ADCSQ_OFS_CTRL2, 8'h16);
      run_conv(8'h17);
      check(acq >= 256 && acq <= 330, 1'b1);
      rd(`ADCSQ_OFS_RES_HIGH, rv);
      check(rv, 8'h59);
      rd(`ADCSQ_OFS_RES_LOW, rv);
      check(rv, 8'h40);
      wr(`ADCSQ_OFS_STATUS, 8'h01);
      $display("test left done");
   endtask

   task test_abort();
      wr(`ADCSQ_OFS_CTRL0, 8'h0F);
      rd(`ADCSQ_OFS_CTRL0, rv);
      check({rv[1], o_analog.hold_open}, 16'h0002);
      wait_hold(1'b1, acq);
      repeat (100) @(posedge i_clock);
      wr(`ADCSQ_OFS_CTRL0, 8'h0D);
      wr(`ADCSQ_OFS_CTRL0, 8'h0F);
      rd(`ADCSQ_OFS_CTRL0, rv);
      check(rv[1], 1'b0);
      repeat (4) @(posedge i_clock);
      #1;
      check(o_analog.hold_open, 1'b0);
      rd(`ADCSQ_OFS_RES_HIGH, rv);
      check(rv, 8'h59);
      rd(`ADCSQ_OFS_RES_LOW, rv);
      check(rv, 8'h40);
      check(o_done_flag, 1'b0);
      repeat (160) @(posedge i_clock);
      $display("test abort done");
   endtask

   task pulse_trigger();
      @(posedge i_clock);
      i_spec_trigger <= 1'b1;
      repeat (4) @(posedge i_clock);
      i_spec_trigger <= 1'b0;
      repeat (8) @(posedge i_clock);
   endtask

   task test_gate();
      wr(`ADCSQ_OFS_CTRL0, 8'h00);
      wr(`ADCSQ_OFS_CTRL0, 8'h02);
      repeat (50) @(posedge i_clock);
      #1;
      check(o_analog.hold_open, 1'b0);
      wr(`ADCSQ_OFS_CTRL0, 8'h00);
      i_ccp_mode <= `ADCSQ_SPEC_TRIG_MODE;
      pulse_trigger();
      rd(`ADCSQ_OFS_CTRL0, rv);
      check(rv[1], 1'b0);
      wr(`ADCSQ_OFS_CTRL0, 8'h0D);
      i_ccp_mode <= 4'h0;
      pulse_trigger();
      rd(`ADCSQ_OFS_CTRL0, rv);
      check(rv[1], 1'b0);
      i_ccp_mode <= `ADCSQ_SPEC_TRIG_MODE;
      pulse_trigger();
      rd(`ADCSQ_OFS_CTRL0, rv);
      check(rv[1], 1'b1);
      wait_hold(1'b1, acq);
      wait_hold(1'b0, conv);
      repeat (160) @(posedge i_clock);
      $display("test gate done");
   endtask

   task test_clocks();
      for (int k = 0; k < 6; k++)
      begin
         wr(`ADCSQ_OFS_CTRL2, {5'h10, 3'(k + k / 3)});
         run_conv(8'h0F);
         check(conv >= 11 * div[k] && conv <= 12 * div[k] + 8, 1'b1);
      end
      wr(`ADCSQ_OFS_CTRL2, 8'h83);
      run_conv(8'h0F);
      check(acq >= 4, 1'b1);
      check(conv >= 100 && conv <= 130, 1'b1);
      rd(`ADCSQ_OFS_RES_LOW, rv);
      check(rv, 8'hE5);
      $display("test clocks done");
   endtask

   // Dummy conversion stores offset 2 and leaves the result pair alone
   task test_calib();
      wr(`ADCSQ_OFS_RES_HIGH, 8'h5A);
      wr(`ADCSQ_OFS_CTRL0, 8'h8D);
      wr(`ADCSQ_OFS_CTRL0, 8'h8F);
      wait_hold(1'b1, acq);
      check(o_analog.calib_cycle, 1'b1);
      wait_hold(1'b0, conv);
      repeat (160) @(posedge i_clock);
      rd(`ADCSQ_OFS_RES_HIGH, rv);
      check(rv, 8'h5A);
      wr(`ADCSQ_OFS_CTRL0, 8'h0D);
      run_conv(8'h0F);
      rd(`ADCSQ_OFS_RES_LOW, rv);
      check(rv, 8'hE3);
      $display("test calib done");
   endtask

   // Reset in mid-conversion aborts it and keeps the result pair
   task test_reset_mid();
      wr(`ADCSQ_OFS_CTRL0, 8'h0F);
      wait_hold(1'b1, acq);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rd(`ADCSQ_OFS_CTRL0, rv);
      check(rv, `ADCSQ_RST_CTRL0);
      check(o_analog.hold_open, 1'b0);
      check(o_dac_code, 16'h0200);
      rd(`ADCSQ_OFS_RES_LOW, rv);
      check(rv, 8'hE3);
      $display("test reset_mid done");
   endtask

   initial
   begin
      i_clock = 1'b0;
      i_rc_clock = 1'b0;
      i_rst_b = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 4'h0;
      i_wdata = 8'h00;
      i_spec_trigger = 1'b0;
      i_ccp_mode = 4'h0;
      num_errors = 0;
      cmp_count = 0;
      repeat (4) @(posedge i_clock);
      i_rst_b <= 1'b1;
      test_reset();
      test_pins();
      test_right();
      test_left();
      test_abort();
      test_gate();
      test_clocks();
      test_calib();
      test_reset_mid();
      results();
   end
endmodule
